/* verilog/xlat_consts.svh */
// Offsets, field positions, reset values and timing counts of the translator
`ifndef XLAT_CONSTS_SVH
`define XLAT_CONSTS_SVH

// Register byte offsets
`define OFS_WIN0_TBASE 12'h0e0
`define OFS_WIN0_SETUP 12'h0e4
`define OFS_WIN1_TBASE 12'h0e8
`define OFS_WIN1_SETUP 12'h0ec
`define OFS_WIN0_BAR 12'h010
`define OFS_WIN1_BAR 12'h014
`define OFS_LAST_XLAT 12'h018

// Field positions
`define WIN0_LOW_BIT 12
`define WIN1_LOW_BIT 6
`define SETUP_TYPE_BIT 0
`define SETUP_ATYPE_LO 1
`define SETUP_ATYPE_HI 2
`define SETUP_PREF_BIT 3
`define SETUP_EN_BIT 31
`define MASK_TOP_BIT 30

// Address type encodings
`define ATYPE_32 2'h0
`define ATYPE_64 2'h1

// Reset values
`define WIN0_EN_RESET 1'h1
`define WIN1_EN_RESET 1'h0
`define BAR_EN_RESET 1'h1

// Answer timing in cycles after the setup edge
`define APB_WAIT_CYCLES 1

`endif

/* verilog/xlat_pkg.sv */
// Types shared by the translator modules
package xlat_pkg;

  typedef logic [31:0] word_t;

  typedef enum {
    SEL_WIN0_TBASE,
    SEL_WIN0_SETUP,
    SEL_WIN1_TBASE,
    SEL_WIN1_SETUP,
    SEL_WIN0_BAR,
    SEL_WIN1_BAR,
    SEL_LAST_XLAT,
    SEL_NONE
  } reg_sel_t;

endpackage

/* verilog/xlat_win_if.sv */
// Signals between the register file and one translation window
`timescale 1ns/1ns
`default_nettype none
interface xlat_win_if;
  logic [31:0] bar;
  logic [31:0] tbase;
  logic [31:0] mask;
  logic en;
  logic req;
  logic [31:0] addr;
  logic hit;
  logic [31:0] xaddr;
  modport ctl (
    output bar, tbase, mask, en, req, addr,
    input hit, xaddr
  );
  modport win (
    input bar, tbase, mask, en, req, addr,
    output hit, xaddr
  );
endinterface
`default_nettype wire

/* verilog/xlat_window.sv */
// Address match and base substitution for one window
`timescale 1ns/1ns
`default_nettype none
module xlat_window #(
  parameter int LOW_BIT = 6,
  parameter bit SKIP_LOW_4K = 1'b0
) (
  xlat_win_if.win w
);

  initial begin
    if (LOW_BIT < 1 || LOW_BIT > 30) begin
      $error("LOW_BIT out of range");
    end
  end

  logic [31:0] cmp;

  // Bit 31 always compared; size mask bits below it are dont-care
  always_comb begin
    cmp = 32'h0;
    for (int i = LOW_BIT; i < 31; i++) begin
      cmp[i] = ~w.mask[i];
    end
    cmp[31] = 1'b1;
  end

  always_comb begin
    w.hit = w.req && w.en && (((w.addr ^ w.bar) & cmp) == 32'h0);
    if (SKIP_LOW_4K && (w.addr[31:12] == 20'h0)) begin
      w.hit = 1'b0;
    end
  end

  // Base bits where the mask is set, original bits elsewhere
  assign w.xaddr = (w.tbase & w.mask) | (w.addr & ~w.mask); // RULE12

endmodule
`default_nettype wire

/* verilog/upstream_address_translation.sv */
// Two upstream address translation windows with their APB register file
//
// Functional notes
// RULE1: Window 0 base bits 31:12 read-write
// RULE2: Window 0 base used only under mask
// RULE3: Type selector bit reads zero, memory
// RULE4: Address type 00 32-bit, 01 64-bit
// RULE5: Mask one makes BAR bit writable
// RULE6: Window 0 enable stays one always
// RULE7: Window 0 BAR unsized bits read ones
// RULE8: Window 1 base bits 31:6 read-write
// RULE9: Window 1 base used only under mask
// RULE10: Software zeroes window 1 mask 11:6
// RULE11: Window 1 enable gates its BAR
// RULE12: Merge base and address by mask
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "xlat_consts.svh"
module upstream_address_translation
  import xlat_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Setup loader (serial ROM side)
  input wire logic setup_load_in,
  input wire logic setup_sel_in,
  input wire logic [31:0] setup_data_in,
  // Upstream request
  input wire logic up_valid_in,
  input wire logic up_is_mem_in,
  input wire logic [ADDR_W-1:0] up_addr_in,
  // Translated request
  output logic up_valid_out,
  output logic [ADDR_W-1:0] up_addr_out,
  output logic [1:0] up_hit_out,
  output logic up_prefetch_out,
  output logic [1:0] up_atype_out
);

  initial begin
    if (ADDR_W != 32) begin
      $error("Only 32-bit upstream addresses are served");
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  function automatic reg_sel_t decode(input logic [11:0] a);
    case ({a[11:2], 2'h0})
      `OFS_WIN0_TBASE: decode = SEL_WIN0_TBASE;
      `OFS_WIN0_SETUP: decode = SEL_WIN0_SETUP;
      `OFS_WIN1_TBASE: decode = SEL_WIN1_TBASE;
      `OFS_WIN1_SETUP: decode = SEL_WIN1_SETUP;
      `OFS_WIN0_BAR: decode = SEL_WIN0_BAR;
      `OFS_WIN1_BAR: decode = SEL_WIN1_BAR;
      `OFS_LAST_XLAT: decode = SEL_LAST_XLAT;
      default: decode = SEL_NONE;
    endcase
  endfunction

  // Byte lanes merged here so partial writes keep the other bytes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  reg_sel_t sel;
  logic wr_en;
  logic setup_phase;

  assign sel = decode(paddr_in);
  assign setup_phase = psel_in && !penable_in;
  assign wr_en = psel_in && penable_in && pready_out && pwrite_in;

  ////////////////////////////////////////////////////////////////////////////

  logic [31:12] tb0_q;
  logic [31:6] tb1_q;
  logic [30:12] mask0_q;
  logic [30:6] mask1_q;
  logic [1:0] atype0_q;
  logic [1:0] atype1_q;
  logic pref0_q;
  logic pref1_q;
  logic en1_q;
  logic [31:12] bar0_q;
  logic [31:6] bar1_q;
  logic [31:0] last_q;
  logic [31:0] bar0_rd;
  logic [31:0] bar1_rd;
  logic [31:0] setup0_rd;
  logic [31:0] setup1_rd;
  logic [31:0] tb_wd;
  logic [31:0] bar_wd;

  // Window 0 BAR bits under a zero mask read as ones, giving the 4KB size at reset; window 1 reads them as zeros
  assign bar0_rd = {bar0_q[31], (bar0_q[30:12] & mask0_q) | ~mask0_q,
                    12'h0}; // RULE7
  assign bar1_rd = {bar1_q[31], bar1_q[30:6] & mask1_q, 6'h0};
  assign setup0_rd = {`WIN0_EN_RESET, mask0_q, 8'h0, pref0_q, atype0_q,
                      1'b0}; // RULE3 RULE6
  assign setup1_rd = {en1_q, mask1_q, 2'h0, pref1_q, atype1_q,
                      1'b0}; // RULE3

  // Translated bases, software writable
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      tb0_q <= 20'h0;
      tb1_q <= 26'h0;
    end else if (wr_en) begin
      if (sel == SEL_WIN0_TBASE) begin
        tb0_q <= tb_wd[31:12]; // RULE1
      end
      if (sel == SEL_WIN1_TBASE) begin
        tb1_q <= tb_wd[31:6]; // RULE8
      end
    end
  end

  always_comb begin
    tb_wd = 32'h0;
    if (sel == SEL_WIN0_TBASE) begin
      tb_wd = merge({tb0_q, 12'h0}, pwdata_in, pstrb_in);
    end else begin
      tb_wd = merge({tb1_q, 6'h0}, pwdata_in, pstrb_in);
    end
  end

  // Setup words are read-only to APB; only the loader changes them
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      mask0_q <= 19'h0;
      mask1_q <= 25'h0;
      atype0_q <= `ATYPE_32; // RULE4
      atype1_q <= `ATYPE_32; // RULE4
      pref0_q <= 1'b0;
      pref1_q <= 1'b0;
      en1_q <= `WIN1_EN_RESET; // RULE11
    end else if (setup_load_in) begin
      if (!setup_sel_in) begin
        mask0_q <= setup_data_in[`MASK_TOP_BIT:`WIN0_LOW_BIT];
        atype0_q <= setup_data_in[`SETUP_ATYPE_HI:`SETUP_ATYPE_LO];
        pref0_q <= setup_data_in[`SETUP_PREF_BIT];
      end else begin
        mask1_q <= setup_data_in[`MASK_TOP_BIT:`WIN1_LOW_BIT];
        atype1_q <= setup_data_in[`SETUP_ATYPE_HI:`SETUP_ATYPE_LO];
        pref1_q <= setup_data_in[`SETUP_PREF_BIT];
        en1_q <= setup_data_in[`SETUP_EN_BIT];
      end
    end
  end

  // Window BARs: bit 31 and the bits whose mask bit is one take a write
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      bar0_q <= {`BAR_EN_RESET, 19'h0};
      bar1_q <= 26'h0;
    end else if (wr_en) begin
      if (sel == SEL_WIN0_BAR) begin
        bar0_q <= {bar_wd[31], (bar_wd[30:12] & mask0_q) |
                   (bar0_q[30:12] & ~mask0_q)}; // RULE5
      end
      if (sel == SEL_WIN1_BAR) begin
        bar1_q <= {bar_wd[31], (bar_wd[30:6] & mask1_q) |
                   (bar1_q[30:6] & ~mask1_q)}; // RULE5
      end
    end
  end

  always_comb begin
    bar_wd = 32'h0;
    if (sel == SEL_WIN0_BAR) begin
      bar_wd = merge({bar0_q, 12'h0}, pwdata_in, pstrb_in);
    end else begin
      bar_wd = merge({bar1_q, 6'h0}, pwdata_in, pstrb_in);
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Read data captured in the setup cycle; answer always one cycle later
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      prdata_out <= 32'h0;
      pslverr_out <= 1'b0;
    end else if (setup_phase) begin
      pslverr_out <= (sel == SEL_NONE);
      case (sel)
        SEL_WIN0_TBASE: prdata_out <= {tb0_q, 12'h0};
        SEL_WIN0_SETUP: prdata_out <= setup0_rd;
        SEL_WIN1_TBASE: prdata_out <= {tb1_q, 6'h0};
        SEL_WIN1_SETUP: prdata_out <= setup1_rd;
        SEL_WIN0_BAR: prdata_out <= bar0_rd;
        SEL_WIN1_BAR: prdata_out <= bar1_rd;
        SEL_LAST_XLAT: prdata_out <= last_q;
        default: prdata_out <= 32'h0;
      endcase
    end
  end

  assign pready_out = psel_in && penable_in;

  ////////////////////////////////////////////////////////////////////////////

  xlat_win_if w0 ();
  xlat_win_if w1 ();

  // Type selector is fixed to memory, so I/O requests never hit
  assign w0.req = up_valid_in && up_is_mem_in;
  assign w0.addr = up_addr_in;
  assign w0.bar = bar0_rd;
  assign w0.tbase = {tb0_q, 12'h0};
  assign w0.mask = {1'b0, mask0_q, 12'h0}; // RULE2
  assign w0.en = `WIN0_EN_RESET; // RULE6

  assign w1.req = up_valid_in && up_is_mem_in;
  assign w1.addr = up_addr_in;
  assign w1.bar = bar1_rd;
  assign w1.tbase = {tb1_q, 6'h0};
  // Mask bits 11:6 assumed zero by software for memory decode
  assign w1.mask = {1'b0, mask1_q, 6'h0}; // RULE9
  assign w1.en = en1_q; // RULE11

  xlat_window #(.LOW_BIT(`WIN0_LOW_BIT), .SKIP_LOW_4K(1'b1)) u_win0 (
    .w(w0.win)
  );

  xlat_window #(.LOW_BIT(`WIN1_LOW_BIT), .SKIP_LOW_4K(1'b0)) u_win1 (
    .w(w1.win)
  );

  // Window 0 wins when both match; one cycle of latency
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      up_valid_out <= 1'b0;
      up_addr_out <= 32'h0;
      up_hit_out <= 2'h0;
      up_prefetch_out <= 1'b0;
      up_atype_out <= `ATYPE_32;
    end else begin
      up_valid_out <= up_valid_in;
      up_hit_out <= {w1.hit && !w0.hit, w0.hit};
      if (w0.hit) begin
        up_addr_out <= w0.xaddr; // RULE12
        up_prefetch_out <= pref0_q;
        up_atype_out <= atype0_q;
      end else if (w1.hit) begin
        up_addr_out <= w1.xaddr; // RULE12
        up_prefetch_out <= pref1_q;
        up_atype_out <= atype1_q;
      end else begin
        up_addr_out <= up_addr_in;
        up_prefetch_out <= 1'b0;
        up_atype_out <= `ATYPE_32;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      last_q <= 32'h0;
    end else if (w0.hit) begin
      last_q <= w0.xaddr;
    end else if (w1.hit) begin
      last_q <= w1.xaddr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Checked on the read path, where software sees the enable
  a_win0_en_stuck: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    setup_phase && sel == SEL_WIN0_SETUP |=> prdata_out[31])
    else $error("window 0 enable dropped"); // RULE6

  a_type_sel_zero: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    setup_phase && (sel == SEL_WIN0_SETUP || sel == SEL_WIN1_SETUP) |=>
    !prdata_out[0])
    else $error("type selector not zero"); // RULE3

  a_io_no_hit: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    up_valid_in && !up_is_mem_in |=> up_hit_out == 2'h0)
    else $error("I/O request hit a window"); // RULE3

  a_win0_low_4k: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    up_addr_in[31:12] == 20'h0 |=> !up_hit_out[0])
    else $error("window 0 hit below 4K"); // RULE1

  a_tb0_write: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    wr_en && sel == SEL_WIN0_TBASE && pstrb_in == 4'hf |=>
    tb0_q == $past(pwdata_in[31:12]))
    else $error("window 0 base write lost"); // RULE1

  a_tb1_write: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    wr_en && sel == SEL_WIN1_TBASE && pstrb_in == 4'hf |=>
    tb1_q == $past(pwdata_in[31:6]))
    else $error("window 1 base write lost"); // RULE8

  a_setup_ro_apb: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !setup_load_in |=> $stable(setup1_rd) && $stable(setup0_rd))
    else $error("setup changed without load"); // RULE4

  a_bar0_unsized: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    setup_phase && sel == SEL_WIN0_BAR |=>
    (prdata_out[30:12] | $past(mask0_q)) == 19'h7ffff)
    else $error("window 0 unsized bit not one"); // RULE7

  a_bar1_ro_bits: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    wr_en && sel == SEL_WIN1_BAR |=>
    ((bar1_q[30:6] ^ $past(bar1_q[30:6])) & ~$past(mask1_q)) == 25'h0)
    else $error("read-only BAR bit changed"); // RULE5

  a_win1_off: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !en1_q && !w0.hit |=> !up_hit_out[1])
    else $error("disabled window 1 hit"); // RULE11

  a_xlat_merge0: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    w0.hit |=> up_addr_out == (($past(w0.tbase) & $past(w0.mask)) |
    ($past(up_addr_in) & ~$past(w0.mask))))
    else $error("window 0 merge wrong"); // RULE12 RULE2

  a_xlat_merge1: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    w1.hit && !w0.hit |=> up_addr_out[5:0] == $past(up_addr_in[5:0]) &&
    up_addr_out[31] == $past(up_addr_in[31]))
    else $error("window 1 kept bits wrong"); // RULE9

  a_apb_answer: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    setup_phase |=> pready_out && (pslverr_out == $past(sel == SEL_NONE)))
    else $error("APB answer late or error flag wrong");

endmodule
`default_nettype wire

/* verification/up_initiator.sv */
// Upstream initiator model that issues one request per call
`timescale 1ns/1ns
`default_nettype none
module up_initiator (
  // Clock
  input wire logic clk_in,
  // Request towards the translator
  output logic valid_out,
  output logic is_mem_out,
  output logic [31:0] addr_out
);
  initial begin
    valid_out = 1'b0;
    is_mem_out = 1'b0;
    addr_out = 32'h0;
  end

  // Released lines show the inverse, so stale values never look valid
  task automatic send(input logic [31:0] a, input logic m);
    @(posedge clk_in);
    valid_out <= 1'b1;
    is_mem_out <= m;
    addr_out <= a;
    @(posedge clk_in);
    valid_out <= 1'b0;
    is_mem_out <= ~m;
    addr_out <= ~a;
  endtask
endmodule
`default_nettype wire

/* verification/test_upstream_address_translation.sv */
// Register and translation tests of the upstream translator
`timescale 1ns/1ns
`default_nettype none
`include "xlat_consts.svh"
module test_upstream_address_translation;
  import xlat_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  word_t pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic ld = 1'b0;
  logic ld_sel = 1'b0;
  word_t ld_data = 32'h0;
  word_t prdata;
  logic pready;
  logic pslverr;
  logic uv_in;
  logic umem;
  word_t ua_in;
  logic uv_out;
  word_t uaddr;
  logic [1:0] uhit;
  logic upref;
  logic [1:0] uatype;
  int error_cnt = 0;
  int n_tests = 0;
  word_t rd;
  logic err;

  always #5 ref_clk_in = ~ref_clk_in;

  upstream_address_translation upstream_address_translation_i (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .setup_load_in(ld), .setup_sel_in(ld_sel), .setup_data_in(ld_data),
    .up_valid_in(uv_in), .up_is_mem_in(umem), .up_addr_in(ua_in),
    .up_valid_out(uv_out), .up_addr_out(uaddr), .up_hit_out(uhit),
    .up_prefetch_out(upref), .up_atype_out(uatype)
  );

  up_initiator up_initiator_i (
    .clk_in(ref_clk_in), .valid_out(uv_in),
    .is_mem_out(umem), .addr_out(ua_in)
  );

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input word_t exp, input word_t got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // Waits for pready; only the watchdog ends a hung wait
  task automatic apb(input logic w, input logic [11:0] a, input word_t d);
    @(posedge ref_clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_in);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk_in);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input word_t exp);
    apb(1'b0, a, 32'h0);
    chk(exp, rd);
  endtask

  task automatic load(input logic s, input word_t d);
    @(posedge ref_clk_in);
    ld <= 1'b1;
    ld_sel <= s;
    ld_data <= d;
    @(posedge ref_clk_in);
    ld <= 1'b0;
  endtask

  // Status word: valid, hit pair, prefetch, address type
  task automatic xlat(input word_t a, input logic m, input word_t ea,
                      input word_t es);
    up_initiator_i.send(a, m);
    #1;
    chk(ea, uaddr);
    chk(es, {26'h0, uv_out, uhit, upref, uatype});
  endtask

  initial begin
    #100000;
    error_cnt++;
    report_and_stop();
  end

  initial begin
    repeat (8) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    rd_chk(`OFS_WIN0_TBASE, 32'h0);
    rd_chk(`OFS_WIN0_SETUP, 32'h80000000);
    rd_chk(`OFS_WIN1_TBASE, 32'h0);
    rd_chk(`OFS_WIN1_SETUP, 32'h0);
    rd_chk(`OFS_WIN0_BAR, 32'hfffff000);
    rd_chk(`OFS_WIN1_BAR, 32'h0);
    $display("test reset values done");
    apb(1'b1, `OFS_WIN0_TBASE, 32'hffffffff);
    rd_chk(`OFS_WIN0_TBASE, 32'hfffff000);
    apb(1'b1, `OFS_WIN1_TBASE, 32'hffffffff);
    rd_chk(`OFS_WIN1_TBASE, 32'hffffffc0);
    apb(1'b1, `OFS_WIN0_SETUP, 32'h0);
    rd_chk(`OFS_WIN0_SETUP, 32'h80000000);
    apb(1'b1, `OFS_WIN0_BAR, 32'h12345000);
    rd_chk(`OFS_WIN0_BAR, 32'h7ffff000);
    apb(1'b0, 12'h100, 32'h0);
    chk(32'h1, {31'h0, err});
    $display("test register access done");
    load(1'b0, 32'h0000f00b);
    rd_chk(`OFS_WIN0_SETUP, 32'h8000f00a);
    apb(1'b1, `OFS_WIN0_BAR, 32'h12345000);
    rd_chk(`OFS_WIN0_BAR, 32'h7fff5000);
    apb(1'b1, `OFS_WIN0_TBASE, 32'habcde000);
    xlat(32'h7fff3456, 1'b1, 32'h7fffe456, 32'h2d);
    xlat(32'h3fff3456, 1'b1, 32'h3fff3456, 32'h20);
    xlat(32'h7fff3456, 1'b0, 32'h7fff3456, 32'h20);
    $display("test window 0 done");
    apb(1'b1, `OFS_WIN1_TBASE, 32'h55556540);
    load(1'b1, 32'h00003008);
    rd_chk(`OFS_WIN1_SETUP, 32'h00003008);
    apb(1'b1, `OFS_WIN1_BAR, 32'h80002000);
    rd_chk(`OFS_WIN1_BAR, 32'h80002000);
    xlat(32'h80001025, 1'b1, 32'h80001025, 32'h20);
    load(1'b1, 32'h80003008);
    apb(1'b1, `OFS_WIN1_SETUP, 32'hffffffff);
    rd_chk(`OFS_WIN1_SETUP, 32'h80003008);
    xlat(32'h80001025, 1'b1, 32'h80002025, 32'h34);
    $display("test window 1 done");
    load(1'b0, 32'h7ffff000);
    xlat(32'h00000123, 1'b1, 32'h00000123, 32'h20);
    xlat(32'h00001123, 1'b1, 32'h2bcde123, 32'h28);
    @(posedge ref_clk_in);
    pstrb <= 4'h2;
    apb(1'b1, `OFS_WIN0_TBASE, 32'h00007700);
    pstrb <= 4'hf;
    rd_chk(`OFS_WIN0_TBASE, 32'habcd7000);
    rd_chk(`OFS_LAST_XLAT, 32'h2bcde123);
    $display("test low edge and byte lanes done");
    report_and_stop();
  end
endmodule
`default_nettype wire
